// file: design/clk_coupling_ctrl.sv
// clock selection, sync clock division and channel coupling of a two channel generator
// assumes pins arrive asynchronously and the register master speaks APB
//
// Functional notes
// - 14 bit: sync clock is ch1 clock / 48
// - 12 bit: sync clock is ch1 clock / 64
// - interpolation: divide by 24 times factor
// - each channel picks internal or external clock
// - different sources: channels run fully independent
// - sample clock out has own source select
// - clock out multiplier 2/4/8 by rate band
// - uncoupled: all settings per channel, async start
// - trigger mode auto, triggered or gated
// - uncoupled: refuse both internal with differing bits
// - uncoupled: clock out source freely selectable
// - coupled: common source, synchronous start
// - coupled: equal fixed delay on both
// - coupled: frequency, source, start, bits shared
// - coupling on copies ch1 shared settings
// - coupled: commands to one act on both
// - coupled: hardware and software drive both
// - coupled: same source and bits, out follows
// - trigger generator period at least five syncs
// - trigger input routable with selectable polarity
`timescale 1ns/1ps
module clk_coupling_ctrl (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              intClkTick,
  input  wire logic              extClkTick,
  input  wire logic              trigIn,
  input  wire logic              eventIn,
  input  wire logic              dynLoadIn,
  output logic                   syncClkOut,
  output logic                   sclkOutExt,
  output logic      [3:0]        sclkOutMult,
  output clk_pkg::ch_out_t       ch1Out,
  output clk_pkg::ch_out_t       ch2Out
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [clk_pkg::PIN_N-1:0] s1;       // first synchroniser stage
    logic [clk_pkg::PIN_N-1:0] s2;
    logic [clk_pkg::PIN_N-1:0] s3;
    logic [clk_pkg::PIN_N-1:0] pin;      // agreed pin levels
    clk_pkg::ctrl_t            ctrl;
    clk_pkg::ch_cfg_t [1:0]    cfg;
    logic [1:0][31:0]          freq;
    logic [31:0]               tgenDiv;
    logic [31:0]               tgenCnt;
    logic [15:0]               rate;
    logic [11:0]               divCnt;   // ch1 ticks in this half period
    logic                      syncClk;
    logic [1:0]                armed;    // started, not stopped
    logic [1:0]                trigSeen;
    clk_pkg::ch_out_t [1:0]    out;
    logic                      cfgErr;   // sticky refused combination
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    logic                      sclkExt;
    logic [3:0]                mult;
  } state_t;

  state_t               q;        // registered state
  state_t               d;        // next state
  logic [4:0]           rise;     // rising edges of agreed pins
  logic [4:0]           fall;     // falling edges of agreed pins
  logic [1:0]           tick;     // selected sample clock per channel
  logic [11:0]          div;      // active sync divisor
  logic                 syncRise;
  logic                 tgenPulse;
  logic                 acc;      // first access cycle
  logic                 done;     // completing access cycle
  logic                 refuse;   // illegal channel write
  logic                 idxCfg;
  logic                 idxFrq;
  logic [31:0]          cmdW;
  logic                 trigE;
  logic                 gateLvl;
  logic [1:0]           startM;
  logic [1:0]           stopM;
  logic [1:0]           trigM;
  logic [1:0]           evtM;
  logic [1:0]           dynM;
  clk_pkg::ctrl_t       nctrl;
  clk_pkg::ch_cfg_t     ncfg;
  clk_pkg::stat_t       stat;

  // ==========================================================
  // decoders
  // sync divisor from bit mode and interpolation setting
  function automatic logic [11:0] divisorOf(input logic b14, input logic ip,
                                            input logic [1:0] sel);
    logic [11:0] f;
    case (sel)
      2'h0:    f = clk_pkg::IP_X3;
      2'h1:    f = clk_pkg::IP_X12;
      2'h2:    f = clk_pkg::IP_X24;
      default: f = clk_pkg::IP_X48;
    endcase
    if (ip) begin
      divisorOf = 12'(clk_pkg::IP_BASE * f);
    end else if (b14) begin
      divisorOf = clk_pkg::DIV_14B;
    end else begin
      divisorOf = clk_pkg::DIV_12B;
    end
  endfunction

  // uncoupled pair legality, symmetric in its arguments
  function automatic logic legalPair(input clk_pkg::ch_cfg_t a,
                                     input clk_pkg::ch_cfg_t b);
    legalPair = !(!a.srcExt && !b.srcExt && (a.bit14 != b.bit14));
  endfunction

  // coupled mode fans any channel request out to both
  function automatic logic [1:0] spread(input logic [1:0] b, input logic c);
    spread = c ? {2{|b}} : b;
  endfunction

  // ==========================================================
  // next state
  // one process computes everything; outputs are the registered copy
  always_comb begin
    d        = q;
    // three stage synchroniser, level accepted when stages 2 and 3 agree
    d.s1     = {dynLoadIn, eventIn, trigIn, extClkTick, intClkTick};
    d.s2     = q.s1;
    d.s3     = q.s2;
    if (q.s2 == q.s3) begin
      d.pin = q.s3;
    end
    rise     = d.pin & ~q.pin;
    fall     = ~d.pin & q.pin;

    // apb: pready rises one cycle into the access, effects at completion
    acc      = psel && penable && !q.pready;
    done     = psel && penable && q.pready;
    idxCfg   = (paddr == clk_pkg::A_CH2);
    idxFrq   = (paddr == clk_pkg::A_FRQ2);
    nctrl    = clk_pkg::ctrl_t'(pwdata[clk_pkg::CTRL_W-1:0]);
    ncfg     = clk_pkg::ch_cfg_t'(pwdata[clk_pkg::CFG_W-1:0]);
    refuse   = pwrite && !q.ctrl.coupled
               && ((paddr == clk_pkg::A_CH1) || (paddr == clk_pkg::A_CH2))
               && !legalPair(ncfg, q.cfg[!idxCfg]);
    stat     = '{bit14: {q.cfg[1].bit14, q.cfg[0].bit14},
                 srcExt: {q.cfg[1].srcExt, q.cfg[0].srcExt},
                 mult: q.mult, sclkExt: q.sclkExt, syncClk: q.syncClk,
                 cfgErr: q.cfgErr, run: {q.out[1].run, q.out[0].run}};
    d.pready = acc;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (acc) begin
      d.pslverr = refuse;
      case (paddr)
        clk_pkg::A_CTRL: d.prdata = 32'(q.ctrl);
        clk_pkg::A_CH1:  d.prdata = 32'(q.cfg[0]);
        clk_pkg::A_CH2:  d.prdata = 32'(q.cfg[1]);
        clk_pkg::A_FRQ1: d.prdata = q.freq[0];
        clk_pkg::A_FRQ2: d.prdata = q.freq[1];
        clk_pkg::A_CMD:  d.prdata = '0;
        clk_pkg::A_TGEN: d.prdata = q.tgenDiv;
        clk_pkg::A_RATE: d.prdata = 32'(q.rate);
        clk_pkg::A_STAT: d.prdata = 32'(stat);
        default:         d.pslverr = 1'b1;  // unmapped
      endcase
    end
    cmdW = '0;
    if (done && pwrite) begin
      case (paddr)
        clk_pkg::A_CTRL: begin
          if (nctrl.coupled && !q.ctrl.coupled) begin
            d.cfg[1].srcExt = q.cfg[0].srcExt;
            d.cfg[1].bit14  = q.cfg[0].bit14;
            d.freq[1]       = q.freq[0];
          end
          d.ctrl = nctrl;
        end
        clk_pkg::A_CH1, clk_pkg::A_CH2: begin
          if (q.ctrl.coupled) begin
            // shared fields land in both, per channel fields only here
            d.cfg[idxCfg]         = ncfg;
            d.cfg[!idxCfg].srcExt = ncfg.srcExt;
            d.cfg[!idxCfg].bit14  = ncfg.bit14;
          end else if (refuse) begin
            d.cfgErr = 1'b1;
          end else begin
            d.cfg[idxCfg] = ncfg;
          end
        end
        clk_pkg::A_FRQ1, clk_pkg::A_FRQ2: begin
          d.freq[idxFrq] = pwdata;
          if (q.ctrl.coupled) begin
            d.freq[!idxFrq] = pwdata;
          end
        end
        clk_pkg::A_CMD:  cmdW = pwdata;
        clk_pkg::A_TGEN: begin
          // clamp keeps the generator at or below a fifth of sync clock
          d.tgenDiv = (pwdata < clk_pkg::TGEN_MIN) ? clk_pkg::TGEN_MIN : pwdata;
        end
        clk_pkg::A_RATE: d.rate = pwdata[15:0];
        clk_pkg::A_STAT: d.cfgErr = 1'b0;  // no refusal can coincide
        default: ;
      endcase
    end

    // per channel sample clock choice
    tick[0] = q.cfg[0].srcExt ? rise[clk_pkg::PIN_EXT] : rise[clk_pkg::PIN_INT];
    tick[1] = q.cfg[1].srcExt ? rise[clk_pkg::PIN_EXT] : rise[clk_pkg::PIN_INT];

    // sync clock always from channel 1; >= recovers when the divisor shrinks
    div      = divisorOf(q.cfg[0].bit14, q.ctrl.interpEn, q.ctrl.interpSel);
    syncRise = 1'b0;
    if (tick[0]) begin
      if (q.divCnt >= ((div >> 1) - clk_pkg::ONE12)) begin
        d.divCnt  = '0;
        d.syncClk = !q.syncClk;
        syncRise  = !q.syncClk;
      end else begin
        d.divCnt = q.divCnt + clk_pkg::ONE12;
      end
    end

    // internal trigger generator counts sync clock periods
    tgenPulse = 1'b0;
    if (!q.ctrl.tgenEn) begin
      d.tgenCnt = '0;
    end else if (syncRise) begin
      if (q.tgenCnt >= (q.tgenDiv - clk_pkg::ONE32)) begin
        d.tgenCnt = '0;
        tgenPulse = 1'b1;
      end else begin
        d.tgenCnt = q.tgenCnt + clk_pkg::ONE32;
      end
    end

    // request fan out, hardware and software alike
    trigE   = q.ctrl.trigPolNeg ? fall[clk_pkg::PIN_TRG] : rise[clk_pkg::PIN_TRG];
    gateLvl = q.pin[clk_pkg::PIN_TRG] ^ q.ctrl.trigPolNeg;
    startM  = spread(cmdW[clk_pkg::CMD_START +: 2], q.ctrl.coupled);
    stopM   = spread(cmdW[clk_pkg::CMD_STOP +: 2], q.ctrl.coupled);
    trigM   = spread(cmdW[clk_pkg::CMD_TRIG +: 2]
                     | ((trigE || tgenPulse) ? q.ctrl.trigRoute : 2'h0),
                     q.ctrl.coupled);
    evtM    = spread(cmdW[clk_pkg::CMD_EVT +: 2]
                     | (rise[clk_pkg::PIN_EVT] ? q.ctrl.evtRoute : 2'h0),
                     q.ctrl.coupled);
    dynM    = spread(cmdW[clk_pkg::CMD_DYN +: 2]
                     | (rise[clk_pkg::PIN_DYN] ? q.ctrl.dynRoute : 2'h0),
                     q.ctrl.coupled);

    // channel run control; each channel uses only its own tick and mode
    for (int i = 0; i < 2; i++) begin
      if (stopM[i]) begin
        d.armed[i]    = 1'b0;
        d.trigSeen[i] = 1'b0;
      end else if (startM[i]) begin
        d.armed[i] = 1'b1;
      end
      if (trigM[i] && q.armed[i]) begin
        d.trigSeen[i] = 1'b1;
      end
      case (q.cfg[i].trigMode)
        clk_pkg::TRIG_AUTO:  d.out[i].run = d.armed[i];
        clk_pkg::TRIG_START: d.out[i].run = d.armed[i] && d.trigSeen[i];
        clk_pkg::TRIG_GATED: begin
          d.out[i].run = d.armed[i] && gateLvl
                         && (q.ctrl.coupled || q.ctrl.trigRoute[i]);
        end
        default:             d.out[i].run = 1'b0;
      endcase
      d.out[i].sampleTick = tick[i] && q.out[i].run;
      d.out[i].trig       = trigM[i];
      d.out[i].evt        = evtM[i];
      d.out[i].dynLoad    = dynM[i] && q.cfg[i].dynEn;
      d.out[i].srcExt     = q.cfg[i].srcExt;
      d.out[i].bit14      = q.cfg[i].bit14;
    end

    // sample clock out source and multiplier
    d.sclkExt = q.ctrl.coupled ? q.cfg[0].srcExt : q.ctrl.sclkOutExt;
    if (q.rate >= clk_pkg::RATE_B2 && q.rate <= clk_pkg::RATE_MAX) begin
      d.mult = clk_pkg::MULT_X2;
    end else if (q.rate >= clk_pkg::RATE_B4 && q.rate < clk_pkg::RATE_B2) begin
      d.mult = clk_pkg::MULT_X4;
    end else if (q.rate >= clk_pkg::RATE_B8 && q.rate < clk_pkg::RATE_B4) begin
      d.mult = clk_pkg::MULT_X8;
    end else begin
      d.mult = clk_pkg::MULT_NO;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      q         <= '0;
      q.tgenDiv <= clk_pkg::TGEN_MIN;
      q.rate    <= clk_pkg::RATE_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign syncClkOut  = q.syncClk;
  assign sclkOutExt  = q.sclkExt;
  assign sclkOutMult = q.mult;
  assign ch1Out      = q.out[0];
  assign ch2Out      = q.out[1];

  // ==========================================================
  // checks
  // half period tick counter, invalidated by any register write
  logic [11:0] hTicks;
  logic        hValid;
  logic        syncTgl;
  assign syncTgl = (d.syncClk != q.syncClk);
  always_ff @(posedge clk) begin
    if (srst || (done && pwrite)) begin
      hTicks <= '0;
      hValid <= 1'b0;
    end else if (syncTgl) begin
      hTicks <= '0;
      hValid <= 1'b1;
    end else if (tick[0]) begin
      hTicks <= hTicks + clk_pkg::ONE12;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_div14;
    syncTgl && hValid && q.cfg[0].bit14 && !q.ctrl.interpEn
      |-> (hTicks + clk_pkg::ONE12) == (clk_pkg::DIV_14B >> 1);
  endproperty
  a_div14: assert property (p_div14) else $error("sync half period not 24");
  property p_div12;
    syncTgl && hValid && !q.cfg[0].bit14 && !q.ctrl.interpEn
      |-> (hTicks + clk_pkg::ONE12) == (clk_pkg::DIV_12B >> 1);
  endproperty
  a_div12: assert property (p_div12) else $error("sync half period not 32");
  property p_divIp;
    syncTgl && hValid && q.ctrl.interpEn && q.ctrl.interpSel == 2'h0
      |-> (hTicks + clk_pkg::ONE12) == 12'h024;
  endproperty
  a_divIp: assert property (p_divIp) else $error("x3 sync half period wrong");
  property p_pairLegal;
    !(!q.cfg[0].srcExt && !q.cfg[1].srcExt && q.cfg[0].bit14 != q.cfg[1].bit14);
  endproperty
  a_pairLegal: assert property (p_pairLegal) else $error("illegal mode pair");
  property p_coupledSame;
    q.ctrl.coupled |-> q.cfg[0].srcExt == q.cfg[1].srcExt
                       && q.cfg[0].bit14 == q.cfg[1].bit14 && q.freq[0] == q.freq[1];
  endproperty
  a_coupledSame: assert property (p_coupledSame) else $error("coupled differ");
  property p_copyOn;
    $rose(q.ctrl.coupled) |-> q.freq[1] == $past(q.freq[0])
                              && q.cfg[1].srcExt == $past(q.cfg[0].srcExt);
  endproperty
  a_copyOn: assert property (p_copyOn) else $error("ch1 not copied");
  property p_syncStart;
    q.ctrl.coupled && (|startM) && !(|stopM) && q.cfg[0].trigMode == q.cfg[1].trigMode
      && q.cfg[0].trigMode != clk_pkg::TRIG_START
      |=> q.armed == 2'h3 ##1 ch1Out.run == ch2Out.run;
  endproperty
  a_syncStart: assert property (p_syncStart) else $error("start not joint");
  property p_bothReq;
    $past(q.ctrl.coupled) |-> ch1Out.trig == ch2Out.trig && ch1Out.evt == ch2Out.evt;
  endproperty
  a_bothReq: assert property (p_bothReq) else $error("coupled request split");
  property p_multX2;
    !$past(srst) && $past(q.rate) >= clk_pkg::RATE_B2 && $past(q.rate) <= clk_pkg::RATE_MAX
      |-> sclkOutMult == clk_pkg::MULT_X2;
  endproperty
  a_multX2: assert property (p_multX2) else $error("band multiplier not 2");
  property p_outSrc;
    !$past(q.ctrl.coupled) |-> sclkOutExt == $past(q.ctrl.sclkOutExt);
  endproperty
  a_outSrc: assert property (p_outSrc) else $error("clock out source wrong");
  property p_tgenMin;
    q.tgenDiv >= clk_pkg::TGEN_MIN;
  endproperty
  a_tgenMin: assert property (p_tgenMin) else $error("generator too fast");
endmodule

// file: design/clk_pkg.sv
// constants and carrier types of the dual channel clock and coupling control
// assumes a 20 MHz system clock and an APB master with 32-bit data
package clk_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;  // coupling, routing, interpolation
  localparam logic [7:0] A_CH1  = 8'h04;  // channel 1 configuration
  localparam logic [7:0] A_CH2  = 8'h08;  // channel 2 configuration
  localparam logic [7:0] A_FRQ1 = 8'h0C;  // channel 1 frequency word
  localparam logic [7:0] A_FRQ2 = 8'h10;  // channel 2 frequency word
  localparam logic [7:0] A_CMD  = 8'h14;  // write-one command strobes
  localparam logic [7:0] A_TGEN = 8'h18;  // trigger generator period
  localparam logic [7:0] A_RATE = 8'h1C;  // internal sample rate in MSa/s
  localparam logic [7:0] A_STAT = 8'h20;  // status, write clears error
  // ==========================================================
  // divider figures
  localparam logic [11:0] DIV_14B  = 12'h030;  // 48
  localparam logic [11:0] DIV_12B  = 12'h040;  // 64
  localparam logic [11:0] IP_BASE  = 12'h018;  // 24
  localparam logic [11:0] IP_X3    = 12'h003;
  localparam logic [11:0] IP_X12   = 12'h00C;
  localparam logic [11:0] IP_X24   = 12'h018;
  localparam logic [11:0] IP_X48   = 12'h030;
  localparam logic [11:0] ONE12    = 12'h001;
  // ==========================================================
  // sample clock output bands, MSa/s
  localparam logic [15:0] RATE_B8  = 16'h007D;  // 125
  localparam logic [15:0] RATE_B4  = 16'h00FA;  // 250
  localparam logic [15:0] RATE_B2  = 16'h01F4;  // 500
  localparam logic [15:0] RATE_MAX = 16'h03E8;  // 1000
  localparam logic [15:0] RATE_RST = 16'h03E8;
  localparam logic [3:0]  MULT_X2  = 4'h2;
  localparam logic [3:0]  MULT_X4  = 4'h4;
  localparam logic [3:0]  MULT_X8  = 4'h8;
  localparam logic [3:0]  MULT_NO  = 4'h0;
  // ==========================================================
  // trigger generator, period in sync clock cycles
  localparam logic [31:0] TGEN_MIN = 32'h0000_0005;
  localparam logic [31:0] ONE32    = 32'h0000_0001;
  // ==========================================================
  // command bit positions, two bits each {ch2, ch1}
  localparam int CMD_START = 0;
  localparam int CMD_STOP  = 2;
  localparam int CMD_TRIG  = 4;
  localparam int CMD_EVT   = 6;
  localparam int CMD_DYN   = 8;
  // pin positions in the synchroniser vector
  localparam int PIN_INT = 0;
  localparam int PIN_EXT = 1;
  localparam int PIN_TRG = 2;
  localparam int PIN_EVT = 3;
  localparam int PIN_DYN = 4;
  localparam int PIN_N   = 5;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    TRIG_AUTO  = 2'b00,
    TRIG_START = 2'b01,
    TRIG_GATED = 2'b10
  } trig_mode_t;
  typedef struct packed {
    logic       tgenEn;      // internal trigger generator on
    logic [1:0] dynRoute;    // dynamic input to {ch2, ch1}
    logic [1:0] evtRoute;    // event input to {ch2, ch1}
    logic       trigPolNeg;  // trigger input active low
    logic [1:0] trigRoute;   // trigger input to {ch2, ch1}
    logic [1:0] interpSel;   // x3, x12, x24, x48
    logic       interpEn;    // interpolation active
    logic       sclkOutExt;  // sample clock out from external input
    logic       coupled;     // channel coupling on
  } ctrl_t;
  localparam int CTRL_W = 13;
  typedef struct packed {
    logic       dynEn;
    trig_mode_t trigMode;
    logic       bit14;       // 1: 14 bit mode, 0: 12 bit mode
    logic       srcExt;      // 1: external sample clock input
  } ch_cfg_t;
  localparam int CFG_W = 5;
  typedef struct packed {
    logic run;
    logic sampleTick;
    logic trig;
    logic evt;
    logic dynLoad;
    logic srcExt;
    logic bit14;
  } ch_out_t;
  typedef struct packed {
    logic [1:0] bit14;
    logic [1:0] srcExt;
    logic [3:0] mult;
    logic       sclkExt;
    logic       syncClk;
    logic       cfgErr;
    logic [1:0] run;
  } stat_t;
endpackage

// file: dv/clk_src_model.sv
// far side model: internal synthesizer and external clock input as tick pins
// assumes a 20 MHz clk; each level is held several cycles for the synchroniser
`timescale 1ns/1ps
module clk_src_model #(
  parameter int INT_HALF = 3,
  parameter int EXT_HALF = 4
) (
  input  wire logic clk,
  output logic      intClkTick,
  output logic      extClkTick
);
  // ==========
  // free running sources
  int intCnt = 0;  // cycles spent in current level
  int extCnt = 0;  // same for the external source
  initial begin
    intClkTick = 1'b0;
    extClkTick = 1'b0;
  end
  // real sample clocks never pause, so neither do these ticks
  always @(posedge clk) begin
    intCnt <= (intCnt == INT_HALF - 1) ? 0 : intCnt + 1;
    extCnt <= (extCnt == EXT_HALF - 1) ? 0 : extCnt + 1;
    if (intCnt == INT_HALF - 1) intClkTick <= ~intClkTick;
    if (extCnt == EXT_HALF - 1) extClkTick <= ~extClkTick;
  end
endmodule

// file: dv/test_dual_channel_clock_coupling_control.sv
// self-checking bench of the clock selection and coupling control
// assumes clk_pkg, clk_coupling_ctrl and clk_src_model are compiled first
`timescale 1ns/1ps
module test_dual_channel_clock_coupling_control;
  // ==========
  // signals, counters and expectation tables
  logic             clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0, prdata, v;
  logic             pready, pslverr, intClkTick, extClkTick, syncClkOut, sclkOutExt;
  logic             trigIn = 1'b0, eventIn = 1'b0, dynLoadIn = 1'b0;
  logic [3:0]       sclkOutMult;
  clk_pkg::ch_out_t ch1Out, ch2Out;
  int               miscompares = 0, nCompared = 0, nInt = 0, nExt = 0, trig1 = 0, trig2 = 0;
  int               ev1 = 0, ev2 = 0, dl2 = 0;
  int               seed, k, rt;
  int               bnd[8] = '{1000, 500, 499, 250, 249, 125, 124, 1001};
  logic [31:0]      dCh[7] = '{32'h0, 32'h2, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0]      dCt[7] = '{32'h0, 32'h0, 32'h0, 32'h4, 32'hC, 32'h14, 32'h1C};
  int               dEx[7] = '{64 / 2, 48 / 2, 48 / 2, 24 * 3 / 2, 24 * 12 / 2, 24 * 24 / 2,
                               24 * 48 / 2};
  always #25 clk = ~clk;
  always @(posedge intClkTick) nInt++;
  always @(posedge extClkTick) nExt++;
  // trigger and event pulses seen per channel, load pulses on ch2 only
  always @(posedge clk) begin
    if (ch1Out.trig === 1'b1) trig1++;
    if (ch2Out.trig === 1'b1) trig2++;
    if (ch1Out.evt === 1'b1) ev1++;
    if (ch2Out.evt === 1'b1) ev2++;
    if (ch2Out.dynLoad === 1'b1) dl2++;
  end
  // event and dynamic pins are pulsed once, in the coupled scenario at the end
  clk_coupling_ctrl clk_coupling_ctrl_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .intClkTick(intClkTick), .extClkTick(extClkTick), .trigIn(trigIn),
    .eventIn(eventIn), .dynLoadIn(dynLoadIn), .syncClkOut(syncClkOut),
    .sclkOutExt(sclkOutExt), .sclkOutMult(sclkOutMult), .ch1Out(ch1Out), .ch2Out(ch2Out));
  clk_src_model clk_src_model_i (.clk(clk), .intClkTick(intClkTick), .extClkTick(extClkTick));
  // ==========
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========
  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    chk(pslverr, e);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    apb(1'b1, a, d, e, r);
  endtask
  // addresses above the status word are unmapped and must be refused
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, a > 8'h20, r);
    chk(r & m, x);
  endtask
  // model of the clock out multiplier; 500 and 250 sit in the upper band
  function automatic logic [3:0] multFor(input int r);
    if (r >= 500 && r <= 1000) return 4'h2;
    if (r >= 250 && r < 500) return 4'h4;
    if (r >= 125 && r < 250) return 4'h8;
    return 4'h0;
  endfunction
  // waits for the next sync clock toggle, counting ticks of the chosen source
  task automatic tog(input logic ext, output int t);
    int n;
    logic s;
    n = 0;
    s = syncClkOut;
    t = ext ? nExt : nInt;
    while (syncClkOut === s && n < 8000) begin
      @(posedge clk);
      n++;
    end
    t = (ext ? nExt : nInt) - t;
    if (n >= 8000) begin
      miscompares++;
      test_done();
    end
  endtask
  // ==========
  // main sequence
  initial begin
    seed = 32'hC302_0992;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(clk_pkg::A_TGEN, 32'h5, 32'hFFFF_FFFF);
    rd(8'h24, 32'h0, 32'hFFFF_FFFF);
    wr(clk_pkg::A_TGEN, 32'h2, 1'b0);
    rd(clk_pkg::A_TGEN, 32'h5, 32'hFFFF_FFFF);
    for (int i = 0; i < 16; i++) begin
      rt = (i < 8) ? bnd[i] : 100 + ($random(seed) & 32'h3FF);
      wr(clk_pkg::A_RATE, rt, 1'b0);
      repeat (3) @(posedge clk);
      chk(sclkOutMult, multFor(rt));
    end
    // ch2 external so every ch1 setting is legal while uncoupled
    wr(clk_pkg::A_CH2, 32'h1, 1'b0);
    wr(clk_pkg::A_CMD, 32'h1, 1'b0);
    for (int i = 0; i < 7; i++) begin
      wr(clk_pkg::A_CH1, dCh[i], 1'b0);
      wr(clk_pkg::A_CTRL, dCt[i], 1'b0);
      tog(dCh[i][0], k);
      tog(dCh[i][0], k);
      chk(k, dEx[i]);
    end
    wr(clk_pkg::A_CTRL, 32'h2, 1'b0);
    repeat (3) @(posedge clk);
    chk(sclkOutExt, 1'b1);
    wr(clk_pkg::A_CH1, 32'h2, 1'b0);
    wr(clk_pkg::A_CH2, 32'h0, 1'b1);
    rd(clk_pkg::A_CH2, 32'h1, 32'h1F);
    rd(clk_pkg::A_STAT, 32'h4, 32'h4);
    wr(clk_pkg::A_STAT, 32'h0, 1'b0);
    rd(clk_pkg::A_STAT, 32'h0, 32'h4);
    wr(clk_pkg::A_CMD, 32'hC, 1'b0);
    // coupling copies ch1 shared settings into ch2
    v = $random(seed);
    wr(clk_pkg::A_CH1, 32'h3, 1'b0);
    wr(clk_pkg::A_FRQ1, v, 1'b0);
    wr(clk_pkg::A_FRQ2, ~v, 1'b0);
    wr(clk_pkg::A_CTRL, 32'h1, 1'b0);
    rd(clk_pkg::A_CH2, 32'h3, 32'h3);
    rd(clk_pkg::A_FRQ2, v, 32'hFFFF_FFFF);
    wr(clk_pkg::A_FRQ2, ~v, 1'b0);
    rd(clk_pkg::A_FRQ1, ~v, 32'hFFFF_FFFF);
    wr(clk_pkg::A_CH2, 32'h0, 1'b0);
    rd(clk_pkg::A_CH1, 32'h0, 32'h3);
    wr(clk_pkg::A_CH1, 32'h3, 1'b0);
    wr(clk_pkg::A_CMD, 32'h2, 1'b0);
    repeat (3) @(posedge clk);
    chk({ch2Out.srcExt, ch2Out.bit14, sclkOutExt}, 3'b111);
    chk({ch1Out.run, ch2Out.run}, 2'b11);
    wr(clk_pkg::A_CMD, 32'h4, 1'b0);
    repeat (3) @(posedge clk);
    chk({ch1Out.run, ch2Out.run}, 2'b00);
    wr(clk_pkg::A_CTRL, 32'h0, 1'b0);
    wr(clk_pkg::A_CMD, 32'h1, 1'b0);
    repeat (3) @(posedge clk);
    chk({ch1Out.run, ch2Out.run}, 2'b10);
    // ch2 armed in triggered mode, pin routed to ch2 only
    wr(clk_pkg::A_CMD, 32'hC, 1'b0);
    wr(clk_pkg::A_CH2, 32'h5, 1'b0);
    wr(clk_pkg::A_CTRL, 32'h40, 1'b0);
    wr(clk_pkg::A_CMD, 32'h2, 1'b0);
    repeat (3) @(posedge clk);
    chk(ch2Out.run, 1'b0);
    trigIn <= 1'b1;
    repeat (4) @(posedge clk);
    trigIn <= 1'b0;
    repeat (8) @(posedge clk);
    chk(ch2Out.run, 1'b1);
    chk(trig1, 32'd0);
    chk(trig2, 32'd1);
    // coupled: pins routed to ch1 only must still reach both channels
    wr(clk_pkg::A_CTRL, 32'h501, 1'b0);
    wr(clk_pkg::A_CH2, 32'h13, 1'b0);
    eventIn <= 1'b1;
    dynLoadIn <= 1'b1;
    repeat (4) @(posedge clk);
    eventIn <= 1'b0;
    dynLoadIn <= 1'b0;
    repeat (8) @(posedge clk);
    chk(ev1, 32'd1);
    chk(ev2, 32'd1);
    chk(dl2, 32'd1);
    test_done();
  end
endmodule
